// >>> include/dpl_pkg.sv
// dpl_pkg: register map, reset values, carriers and damping lookup for the loop control
package dpl_pkg;
  localparam logic [7:0] DPL_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPL_BW_OFS = 8'h04;
  localparam logic [7:0] DPL_DAMP_OFS = 8'h08;
  localparam logic [7:0] DPL_MC_OFS = 8'h0c;
  localparam logic [7:0] DPL_LOSS_EN_OFS = 8'h10;
  localparam logic [7:0] DPL_WEIGHT_OFS = 8'h14;
  localparam logic [7:0] DPL_FINE_THR_OFS = 8'h18;
  localparam logic [7:0] DPL_STATUS_OFS = 8'h1c;
  localparam logic [7:0] DPL_PPHASE_OFS = 8'h20;
  localparam logic [7:0] DPL_SPHASE_OFS = 8'h24;
  localparam logic [7:0] DPL_DIV_OFS = 8'h28;

  // ctrl bit positions
  localparam int DPL_CTRL_AUTO_BW = 0;
  localparam int DPL_CTRL_NE_DIS = 1;
  localparam int DPL_CTRL_MC_EN = 2;
  localparam int DPL_CTRL_MC_IN_LOOP = 3;
  localparam int DPL_CTRL_P_DIV8K = 4;
  localparam int DPL_CTRL_S_DIV8K = 5;
  localparam int DPL_CTRL_S_MEASURE = 6;

  localparam logic [6:0] DPL_CTRL_RST = 7'h01;
  localparam logic [3:0] DPL_LOCKED_BW_RST = 4'h4;
  localparam logic [3:0] DPL_ACQ_BW_RST = 4'h7;
  localparam logic [1:0] DPL_SEC_BW_RST = 2'h0;
  // damping code 3 keeps gain peak near 0.1 dB at every bandwidth
  localparam logic [2:0] DPL_DAMP_RST = 3'h3;
  localparam logic [3:0] DPL_MC_RANGE_RST = 4'h3;
  localparam logic [3:0] DPL_LOSS_EN_RST = 4'hf;
  localparam logic [7:0] DPL_PFD_W_RST = 8'h10;
  localparam logic [7:0] DPL_EL_W_RST = 8'h01;
  localparam logic [15:0] DPL_FINE_THR_RST = 16'h0040;
  localparam logic [15:0] DPL_DIV_RST = 16'h0001;

  // secondary bandwidth codes map onto primary codes 7, 8, 9 (18, 35, 70 Hz)
  localparam logic [3:0] DPL_BW_4HZ = 4'h5;
  localparam logic [3:0] DPL_BW_8HZ = 4'h6;
  localparam logic [3:0] DPL_BW_18HZ = 4'h7;
  localparam logic [3:0] DPL_BW_35HZ = 4'h8;
  localparam logic [3:0] DPL_BW_70HZ = 4'h9;

  // slowest input is 2 kHz, so an input idle for one such period is dead
  localparam int DPL_CLK_PERIOD_NS = 4;
  localparam int DPL_ACT_TIMEOUT_NS = 500000;
  localparam int DPL_ACT_CYCLES = DPL_ACT_TIMEOUT_NS / DPL_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DPL_DF_1P2 = 3'b000,
    DPL_DF_2P5 = 3'b001,
    DPL_DF_5 = 3'b010,
    DPL_DF_10 = 3'b011,
    DPL_DF_20 = 3'b100
  } dpl_damp_t;

  typedef struct packed {
    logic [3:0] bw_sel;
    dpl_damp_t damping;
    logic locked;
    logic near_edge;
    logic [3:0] loss;
    logic signed [31:0] err;
  } dpl_loop_out_t;

  function automatic dpl_damp_t dpl_damping(input logic [3:0] bw, input logic [2:0] code);
    dpl_damp_t df;
    df = DPL_DF_5;
    if (bw == DPL_BW_8HZ) begin
      if (code == 3'h1) df = DPL_DF_2P5;
    end else if (bw >= DPL_BW_18HZ && bw <= DPL_BW_70HZ) begin
      case (code)
        3'h1: df = DPL_DF_1P2;
        3'h2: df = DPL_DF_2P5;
        3'h4: df = (bw == DPL_BW_18HZ) ? DPL_DF_5 : DPL_DF_10;
        3'h5: df = (bw == DPL_BW_18HZ) ? DPL_DF_5 :
                   (bw == DPL_BW_35HZ) ? DPL_DF_10 : DPL_DF_20;
        default: df = DPL_DF_5;
      endcase
    end
    return df;
  endfunction
endpackage

// >>> hw/dpl_phase_det.sv
// dpl_phase_det: phase/frequency, early/late and multi-cycle detector for one loop
`timescale 1ns/1ps
module dpl_phase_det #(
  parameter int PW = 24,
  parameter int CW = 14,
  parameter int TW = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_in,
  input wire logic fb_in,
  input wire logic div_en,
  input wire logic [15:0] div_ratio,
  input wire logic mc_in_loop,
  input wire logic mc_en,
  input wire logic [3:0] mc_range,
  input wire logic near_edge,
  input wire logic [TW-1:0] act_limit,
  output logic signed [PW-1:0] phase,
  output logic signed [PW-1:0] loop_phase,
  output logic slip,
  output logic no_act
);
  typedef struct packed {
    logic ref_d;
    logic fb_d;
    logic [15:0] div_cnt;
    logic [PW-1:0] t;
    logic [PW-1:0] per;
    logic signed [CW-1:0] cyc;
    logic signed [PW-1:0] ph;
    logic signed [PW-1:0] lp;
    logic slip;
    logic [TW-1:0] idle;
    logic no_act;
  } dpl_pd_state_t;

  dpl_pd_state_t s_reg, s_next;
  logic ref_rise;
  logic fb_rise;
  logic ref_evt;
  logic signed [CW-1:0] lim;
  logic signed [PW-1:0] raw;
  logic signed [PW+CW-1:0] span;

  always_comb begin
    s_next = s_reg;
    // every pclk samples the pin, so each level must last at least one clock
    ref_rise = ref_in & ~s_reg.ref_d;
    fb_rise = fb_in & ~s_reg.fb_d;
    s_next.ref_d = ref_in;
    s_next.fb_d = fb_in;
    // divide-to-8k: only every div_ratio-th reference edge is compared
    ref_evt = ref_rise;
    if (div_en && ref_rise) begin
      ref_evt = (s_reg.div_cnt >= div_ratio - 16'h0001);
      s_next.div_cnt = ref_evt ? 16'h0000 : s_reg.div_cnt + 16'h0001;
    end
    // time since reference edge, in whole clock cycles
    // the ref edge itself counts, so a feedback edge k cycles later reads k
    if (ref_evt) begin
      s_next.t = PW'(1);
      s_next.per = s_reg.t;
    end else if (~&s_reg.t) begin
      s_next.t = s_reg.t + 1'b1;
    end
    // multi-cycle count always tracks, clamped to 2^(n+1)-1 UI
    // ranges past 12 stop at the 8191 UI ceiling so the count cannot wrap
    lim = CW'((32'sd2 <<< ((mc_range > 4'hc) ? 4'hc : mc_range)) - 32'sd1);
    if (ref_evt && !fb_rise) begin
      s_next.cyc = (s_reg.cyc >= lim) ? lim : s_reg.cyc + 1'b1;
    end else if (fb_rise && !ref_evt) begin
      s_next.cyc = (s_reg.cyc <= -lim) ? -lim : s_reg.cyc - 1'b1;
    end
    // coarse detector: n whole cycles of slip
    s_next.slip = (s_next.cyc >= lim) || (s_next.cyc <= -lim);
    // nearest edge folds into +-180 degrees, else 0 to +360
    // coincident edges are zero phase, not a whole period
    raw = ref_evt ? '0 : $signed(s_reg.t);
    if (near_edge && !ref_evt && (s_reg.t > (s_reg.per >> 1))) begin
      raw = $signed(s_reg.t - s_reg.per);
    end
    // whole cycles still open once this feedback edge has been counted
    span = PW'(raw) + s_next.cyc * $signed({1'b0, s_reg.per[PW-2:0]});
    if (fb_rise) begin
      s_next.ph = raw;
      // full multi-cycle value in loop, else limited to one cycle
      s_next.lp = (mc_en && mc_in_loop) ? span[PW-1:0] : raw;
    end
    // input activity monitor
    if (ref_rise) begin
      s_next.idle = '0;
    end else if (~&s_reg.idle) begin
      s_next.idle = s_reg.idle + 1'b1;
    end
    s_next.no_act = (s_reg.idle >= act_limit);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign phase = s_reg.ph;
  assign loop_phase = s_reg.lp;
  assign slip = s_reg.slip;
  assign no_act = s_reg.no_act;
endmodule

// >>> hw/dpl_loop_ctrl.sv
// dpl_loop_ctrl: apb-controlled phase detection and loop control for both timing loops
//
// Summary of operation
// - secondary loop has one bandwidth setting chosen from 18, 35 or 70 Hz.
// - damping factor programmable among 1.2, 2.5, 5, 10 and 20.
// - secondary loop runs independently, alongside the primary loop.
// - secondary loop usable as frame-sync loop or input-to-input phase meter.
// - auto mode uses acquisition bandwidth unlocked, locked bandwidth once locked.
// - detector takes inputs from 2 kHz up to 77.76 MHz.
// - divide-to-8k bit divides the reference to 8 kHz before comparison.
// - nearest-edge capture spans +-180 degrees; normal spans 0 to +360 and frequency locks.
// - nearest-edge selected automatically when multi-cycle is off and locked.
// - nearest-edge disable bit forbids nearest-edge, keeps frequency locking.
// - multi-cycle enable bit; 4-bit range 1, 3, 7, 15 up to 8191 UI.
// - in-loop bit uses full multi-cycle phase, else limited to 360 degrees.
// - multi-cycle detector tracks target phase regardless of in-loop bit.
// - four phase-loss sources, each with its own enable bit.
// - lock state steers nearest-edge choice and bandwidth choice.
// - coarse detector flags loss at n cycles, n from the range field.
// - damping table for 0.1 to 18 Hz bandwidths per 3-bit code.
// - damping table for 35 Hz and 70 Hz bandwidths per code.
// - default damping keeps wander gain peak near 0.1 dB.
// - registers weight the frequency and early/late detectors.
// - loop logic runs on the internal clock; resolution is one cycle.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module dpl_loop_ctrl
  import dpl_pkg::*;
#(
  parameter int ACT_CYCLES = dpl_pkg::DPL_ACT_CYCLES,
  parameter int PW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primary_ref,
  input wire logic primary_fb,
  input wire logic primary_freq_limit,
  input wire logic secondary_ref,
  input wire logic secondary_fb,
  input wire logic secondary_freq_limit,
  output dpl_pkg::dpl_loop_out_t primary_out,
  output dpl_pkg::dpl_loop_out_t secondary_out
);
  import dpl_pkg::*;

  localparam int TW = 20;

  typedef struct packed {
    logic [6:0] ctrl;
    logic [3:0] locked_bw;
    logic [3:0] acq_bw;
    logic [1:0] sec_bw;
    logic [2:0] p_damp;
    logic [2:0] s_damp;
    logic [3:0] mc_range;
    logic [3:0] loss_en;
    logic [7:0] pfd_w;
    logic [7:0] el_w;
    logic [15:0] fine_thr;
    logic [15:0] p_div;
    logic [15:0] s_div;
    logic [31:0] rdata;
    dpl_loop_out_t p;
    dpl_loop_out_t s;
  } dpl_state_t;

  dpl_state_t st_reg, st_next;

  logic signed [PW-1:0] p_phase, p_loop, s_phase, s_loop;
  logic p_slip, p_noact, s_slip, s_noact;
  logic p_mc_en, p_ne, s_ne;
  logic s_fb_sel;
  logic [TW-1:0] act_lim;
  logic mapped;

  assign act_lim = TW'(ACT_CYCLES);
  assign p_mc_en = st_reg.ctrl[DPL_CTRL_MC_EN];
  assign p_ne = st_reg.p.near_edge;
  assign s_ne = st_reg.s.near_edge;
  // phase-meter mode compares the secondary reference against the primary one
  assign s_fb_sel = st_reg.ctrl[DPL_CTRL_S_MEASURE] ? primary_ref : secondary_fb;

  // both loops share one detector design and the multi-cycle controls, but each keeps its own state
  dpl_phase_det #(.PW(PW), .CW(14), .TW(TW)) u_pd_primary (
    .pclk(pclk),
    .presetn(presetn),
    .ref_in(primary_ref),
    .fb_in(primary_fb),
    .div_en(st_reg.ctrl[DPL_CTRL_P_DIV8K]),
    .div_ratio(st_reg.p_div),
    .mc_in_loop(st_reg.ctrl[DPL_CTRL_MC_IN_LOOP]),
    .mc_en(p_mc_en),
    .mc_range(st_reg.mc_range),
    .near_edge(p_ne),
    .act_limit(act_lim),
    .phase(p_phase),
    .loop_phase(p_loop),
    .slip(p_slip),
    .no_act(p_noact)
  );

  dpl_phase_det #(.PW(PW), .CW(14), .TW(TW)) u_pd_secondary (
    .pclk(pclk),
    .presetn(presetn),
    .ref_in(secondary_ref),
    .fb_in(s_fb_sel),
    .div_en(st_reg.ctrl[DPL_CTRL_S_DIV8K]),
    .div_ratio(st_reg.s_div),
    .mc_in_loop(st_reg.ctrl[DPL_CTRL_MC_IN_LOOP]),
    .mc_en(p_mc_en),
    .mc_range(st_reg.mc_range),
    .near_edge(s_ne),
    .act_limit(act_lim),
    .phase(s_phase),
    .loop_phase(s_loop),
    .slip(s_slip),
    .no_act(s_noact)
  );

  // combine detector terms: pfd part scaled by 1/16, early/late adds a signed step
  function automatic logic signed [31:0] weigh(input logic signed [PW-1:0] ph,
                                               input logic [7:0] pw,
                                               input logic [7:0] ew);
    logic signed [31:0] prod;
    logic signed [31:0] el;
    prod = (32'(ph) * $signed({24'h000000, pw})) >>> 4;
    el = (ph < 0) ? -$signed({24'h000000, ew}) : $signed({24'h000000, ew});
    return prod + ((ph == 0) ? 32'sh00000000 : el);
  endfunction

  function automatic logic fine_loss(input logic signed [PW-1:0] ph,
                                     input logic [15:0] thr);
    logic signed [PW-1:0] mag;
    mag = (ph < 0) ? -ph : ph;
    return mag > $signed({{(PW-16){1'b0}}, thr});
  endfunction

  always_comb begin
    logic [3:0] p_loss;
    logic [3:0] s_loss;
    logic [3:0] s_bw_code;
    logic [3:0] p_bw_code;
    logic p_lock;
    logic s_lock;
    p_loss = '0;
    s_loss = '0;
    s_bw_code = '0;
    p_bw_code = '0;
    p_lock = 1'b0;
    s_lock = 1'b0;
    st_next = st_reg;
    mapped = 1'b1;

    // register writes take effect at the access edge
    if (psel && penable && pwrite) begin
      case (paddr)
        DPL_CTRL_OFS: st_next.ctrl = pwdata[6:0];
        DPL_BW_OFS: begin
          st_next.locked_bw = pwdata[3:0];
          st_next.acq_bw = pwdata[7:4];
          // only three secondary settings exist; code 3 is held off
          if (pwdata[9:8] != 2'h3) st_next.sec_bw = pwdata[9:8];
        end
        DPL_DAMP_OFS: begin
          st_next.p_damp = pwdata[2:0];
          st_next.s_damp = pwdata[6:4];
        end
        DPL_MC_OFS: st_next.mc_range = pwdata[3:0];
        DPL_LOSS_EN_OFS: st_next.loss_en = pwdata[3:0];
        DPL_WEIGHT_OFS: begin
          st_next.pfd_w = pwdata[7:0];
          st_next.el_w = pwdata[15:8];
        end
        DPL_FINE_THR_OFS: st_next.fine_thr = pwdata[15:0];
        DPL_DIV_OFS: begin
          st_next.p_div = pwdata[15:0];
          st_next.s_div = pwdata[31:16];
        end
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end

    // read data is latched in the setup cycle so the answer comes from a flop
    case (paddr)
      DPL_CTRL_OFS: st_next.rdata = {25'h0000000, st_reg.ctrl};
      DPL_BW_OFS: st_next.rdata = {22'h000000, st_reg.sec_bw, st_reg.acq_bw,
                                   st_reg.locked_bw};
      DPL_DAMP_OFS: st_next.rdata = {25'h0000000, st_reg.s_damp, 1'b0, st_reg.p_damp};
      DPL_MC_OFS: st_next.rdata = {28'h0000000, st_reg.mc_range};
      DPL_LOSS_EN_OFS: st_next.rdata = {28'h0000000, st_reg.loss_en};
      DPL_WEIGHT_OFS: st_next.rdata = {16'h0000, st_reg.el_w, st_reg.pfd_w};
      DPL_FINE_THR_OFS: st_next.rdata = {16'h0000, st_reg.fine_thr};
      DPL_STATUS_OFS: st_next.rdata = {5'h00, st_reg.s.damping, st_reg.s.bw_sel,
                                       st_reg.s.loss, st_reg.s.near_edge,
                                       st_reg.s.locked, 1'b0, st_reg.p.damping,
                                       st_reg.p.bw_sel, st_reg.p.loss,
                                       st_reg.p.near_edge, st_reg.p.locked};
      DPL_PPHASE_OFS: st_next.rdata = 32'(p_phase);
      DPL_SPHASE_OFS: st_next.rdata = 32'(s_phase);
      DPL_DIV_OFS: st_next.rdata = {st_reg.s_div, st_reg.p_div};
      default: begin
        st_next.rdata = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
    if (!(psel && !penable)) st_next.rdata = st_reg.rdata;

    // four individually enabled loss sources: fine, coarse, freq limit, activity
    p_loss = {p_noact, primary_freq_limit, p_slip,
              fine_loss(p_phase, st_reg.fine_thr)} & st_reg.loss_en;
    s_loss = {s_noact, secondary_freq_limit, s_slip,
              fine_loss(s_phase, st_reg.fine_thr)} & st_reg.loss_en;
    p_lock = ~|p_loss;
    s_lock = ~|s_loss;
    st_next.p.loss = p_loss;
    st_next.s.loss = s_loss;
    st_next.p.locked = p_lock;
    st_next.s.locked = s_lock;

    // lock state picks nearest edge; disable bit keeps frequency locking
    st_next.p.near_edge = p_lock && !p_mc_en && !st_reg.ctrl[DPL_CTRL_NE_DIS];
    st_next.s.near_edge = s_lock && !p_mc_en && !st_reg.ctrl[DPL_CTRL_NE_DIS];

    // acquisition bandwidth only while unlocked and auto mode is on
    p_bw_code = (st_reg.ctrl[DPL_CTRL_AUTO_BW] && !p_lock) ? st_reg.acq_bw
                                                           : st_reg.locked_bw;
    st_next.p.bw_sel = p_bw_code;
    // secondary codes 0..2 land on 18, 35, 70 Hz
    case (st_reg.sec_bw)
      2'h1: s_bw_code = DPL_BW_35HZ;
      2'h2: s_bw_code = DPL_BW_70HZ;
      default: s_bw_code = DPL_BW_18HZ;
    endcase
    st_next.s.bw_sel = s_bw_code;

    // damping follows the bandwidth actually in use
    st_next.p.damping = dpl_damping(p_bw_code, st_reg.p_damp);
    st_next.s.damping = dpl_damping(s_bw_code, st_reg.s_damp);

    st_next.p.err = weigh(p_loop, st_reg.pfd_w, st_reg.el_w);
    st_next.s.err = weigh(s_loop, st_reg.pfd_w, st_reg.el_w);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl <= DPL_CTRL_RST;
      st_reg.locked_bw <= DPL_LOCKED_BW_RST;
      st_reg.acq_bw <= DPL_ACQ_BW_RST;
      st_reg.sec_bw <= DPL_SEC_BW_RST;
      st_reg.p_damp <= DPL_DAMP_RST;
      st_reg.s_damp <= DPL_DAMP_RST;
      st_reg.mc_range <= DPL_MC_RANGE_RST;
      st_reg.loss_en <= DPL_LOSS_EN_RST;
      st_reg.pfd_w <= DPL_PFD_W_RST;
      st_reg.el_w <= DPL_EL_W_RST;
      st_reg.fine_thr <= DPL_FINE_THR_RST;
      st_reg.p_div <= DPL_DIV_RST;
      st_reg.s_div <= DPL_DIV_RST;
      st_reg.p.damping <= DPL_DF_5;
      st_reg.s.damping <= DPL_DF_5;
    end else begin
      st_reg <= st_next;
    end
  end

  // zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st_reg.rdata;
  assign primary_out = st_reg.p;
  assign secondary_out = st_reg.s;
endmodule

// >>> verif/dpl_loop_ctrl_assertions.sv
// dpl_loop_ctrl_assertions: port-level checks of bandwidth, lock and damping choice
`timescale 1ns/1ps
module dpl_loop_ctrl_assertions
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire dpl_pkg::dpl_loop_out_t primary_out,
  input wire dpl_pkg::dpl_loop_out_t secondary_out
);
  typedef struct packed {
    logic [6:0] ctrl;
    logic [9:0] bw;
    logic [3:0] len;
  } dpl_shadow_t;
  dpl_shadow_t sh_reg, sh_next;
  logic wr;
  assign wr = psel && penable && pwrite;
  // shadow of the config that steers the outputs; a code 3 secondary field is dropped
  always_comb begin
    sh_next = sh_reg;
    if (wr && paddr == DPL_CTRL_OFS) sh_next.ctrl = pwdata[6:0];
    if (wr && paddr == DPL_BW_OFS) begin
      sh_next.bw[7:0] = pwdata[7:0];
      if (pwdata[9:8] != 2'h3) sh_next.bw[9:8] = pwdata[9:8];
    end
    if (wr && paddr == DPL_LOSS_EN_OFS) sh_next.len = pwdata[3:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= {DPL_CTRL_RST, DPL_SEC_BW_RST, DPL_ACQ_BW_RST, DPL_LOCKED_BW_RST, DPL_LOSS_EN_RST};
    end else begin
      sh_reg <= sh_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // outputs lag a write by one edge, so that edge is skipped
  auto_bw_use_a: assert property ($past(presetn, 2) && !$past(wr) |->
    primary_out.bw_sel == ((sh_reg.ctrl[0] && !primary_out.locked) ? sh_reg.bw[7:4] : sh_reg.bw[3:0]))
    else $error("primary bandwidth wrong");
  sec_bw_map_a: assert property ($past(presetn, 2) && !$past(wr) |->
    secondary_out.bw_sel == DPL_BW_18HZ + {2'h0, sh_reg.bw[9:8]})
    else $error("secondary bandwidth wrong");
  ne_disable_a: assert property ($past(presetn, 2) && !$past(wr) && sh_reg.ctrl[1] |->
    !primary_out.near_edge && !secondary_out.near_edge)
    else $error("nearest edge while disabled");
  ne_mc_block_a: assert property ($past(presetn, 2) && !$past(wr) && sh_reg.ctrl[2] |->
    !primary_out.near_edge && !secondary_out.near_edge)
    else $error("nearest edge with multi-cycle on");
  ne_needs_lock_a: assert property (primary_out.near_edge |-> primary_out.locked)
    else $error("nearest edge without lock");
  loss_mask_a: assert property ($past(presetn, 2) && !$past(wr) |->
    ((primary_out.loss | secondary_out.loss) & ~sh_reg.len) == 4'h0)
    else $error("disabled loss source shown");
  lock_from_loss_a: assert property ($past(presetn, 2) |->
    primary_out.locked == (primary_out.loss == 4'h0))
    else $error("lock disagrees with loss");
  low_bw_damp_a: assert property (primary_out.bw_sel <= DPL_BW_4HZ |->
    primary_out.damping == DPL_DF_5)
    else $error("low bandwidth damping wrong");
  top_damp_a: assert property (primary_out.damping == DPL_DF_20 |->
    primary_out.bw_sel == DPL_BW_70HZ)
    else $error("damping 20 below 70 Hz");
endmodule

// >>> verif/dpl_ref_src.sv
// dpl_ref_src: reference and feedback clock pair for one loop
`timescale 1ns/1ps
module dpl_ref_src #(
  parameter int PER = 40,
  parameter int DLY = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic ref_clk,
  output logic fb_clk
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    end
  end
  // a stopped input stands low, as a dead line would
  assign ref_clk = run && (cnt < PER / 2);
  assign fb_clk = (cnt >= DLY) && (cnt < DLY + PER / 2);
endmodule

// >>> verif/dpll_phase_detect_loop_control_tb_top.sv
// dpll_phase_detect_loop_control_tb_top: register, damping, lock and loss scenarios
`timescale 1ns/1ps
module dpll_phase_detect_loop_control_tb_top;
  import dpl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, acc;
  logic p_ref, p_fb, s_ref, s_fb, p_run, s_run, p_lim, s_lim;
  dpl_loop_out_t p_out, s_out;
  int err_count, compares;
  // locked bw code, then expected damping for codes 1..5
  logic [18:0] rows [5];
  logic [39:0] rst_rows [8];

  dpl_loop_ctrl #(.ACT_CYCLES(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primary_ref(p_ref), .primary_fb(p_fb),
    .primary_freq_limit(p_lim), .secondary_ref(s_ref), .secondary_fb(s_fb),
    .secondary_freq_limit(s_lim), .primary_out(p_out), .secondary_out(s_out));
  dpl_ref_src #(.PER(40), .DLY(5)) u_pri (.pclk(pclk), .presetn(presetn), .run(p_run),
    .ref_clk(p_ref), .fb_clk(p_fb));
  dpl_ref_src #(.PER(40), .DLY(9)) u_sec (.pclk(pclk), .presetn(presetn), .run(s_run),
    .ref_clk(s_ref), .fb_clk(s_fb));

  task automatic complete_run();
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // stands in for the external master oscillator
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {p_run, s_run, p_lim, s_lim} = 4'hc;
    err_count = 0;
    compares = 0;
    rows = '{{4'h5, 15'o22222}, {4'h6, 15'o12222}, {4'h7, 15'o01222},
             {4'h8, 15'o01233}, {4'h9, 15'o01234}};
    rst_rows = '{40'h0000000001, 40'h0400000074, 40'h0800000033, 40'h0c00000003,
                 40'h100000000f, 40'h1400000110, 40'h1800000040, 40'h2800010001};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_rows[i]) begin
      apb(1'b0, rst_rows[i][39:32], 32'h0);
      chk("reset value", rst_rows[i][31:0], rd);
    end
    apb(1'b1, 8'h40, 32'hffffffff);
    chk("unmapped write error", 32'h1, {31'h0, er});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    apb(1'b1, DPL_BW_OFS, 32'h174);
    apb(1'b1, DPL_BW_OFS, 32'h374);
    apb(1'b0, DPL_BW_OFS, 32'h0);
    chk("secondary bw refused", 32'h174, rd);
    chk("secondary bw 35", {28'h0, DPL_BW_35HZ}, {28'h0, s_out.bw_sel});
    apb(1'b1, DPL_CTRL_OFS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, DPL_BW_OFS, {22'h0, (i > 1) ? 2'(i - 2) : 2'h0, 4'h0, rows[i][18:15]});
      for (int c = 1; c <= 5; c++) begin
        apb(1'b1, DPL_DAMP_OFS, {25'h0, 3'(c), 1'b0, 3'(c)});
        idle(2);
        chk("primary bw", {28'h0, rows[i][18:15]}, {28'h0, p_out.bw_sel});
        chk("primary damping", {29'h0, rows[i][17-3*c -: 3]}, {29'h0, p_out.damping});
        if (i > 1) chk("secondary damping", {29'h0, rows[i][17-3*c -: 3]},
          {29'h0, s_out.damping});
      end
    end
    apb(1'b1, DPL_DIV_OFS, 32'h00010002);
    apb(1'b1, DPL_CTRL_OFS, 32'h12);
    idle(200);
    apb(1'b0, DPL_PPHASE_OFS, 32'h0);
    acc = rd;
    idle(37);
    apb(1'b0, DPL_PPHASE_OFS, 32'h0);
    // reads 40 cycles apart see a counted and a skipped ref edge: 5 and 45
    chk("divided phase sum", 32'h32, acc + rd);
    apb(1'b1, DPL_CTRL_OFS, 32'h1);
    apb(1'b1, DPL_BW_OFS, 32'h074);
    idle(100);
    apb(1'b0, DPL_PPHASE_OFS, 32'h0);
    chk("primary phase", 32'h5, rd);
    apb(1'b0, DPL_SPHASE_OFS, 32'h0);
    chk("secondary phase", 32'h9, rd);
    chk("locked bw in use", 32'hc4,
      {24'h0, p_out.locked, p_out.near_edge, 2'h0, p_out.bw_sel});
    chk("primary err", 32'h6, p_out.err);
    apb(1'b1, DPL_WEIGHT_OFS, 32'h0320);
    idle(2);
    chk("weighted err", 32'hd, p_out.err);
    apb(1'b1, DPL_CTRL_OFS, 32'h41);
    idle(100);
    apb(1'b0, DPL_SPHASE_OFS, 32'h0);
    chk("phase meter", 32'h0, rd);
    apb(1'b1, DPL_CTRL_OFS, 32'h3);
    idle(3);
    chk("ne disabled", 32'h2, {30'h0, p_out.locked, p_out.near_edge});
    apb(1'b1, DPL_CTRL_OFS, 32'h5);
    idle(3);
    chk("ne blocked by mc", 32'h0, {31'h0, p_out.near_edge});
    apb(1'b1, DPL_CTRL_OFS, 32'h1);
    p_run <= 1'b0;
    idle(100);
    // once unlocked the stale phase is no longer folded and trips the fine detector
    chk("activity loss", 32'h097, {23'h0, p_out.locked, p_out.loss, p_out.bw_sel});
    apb(1'b1, DPL_LOSS_EN_OFS, 32'h6);
    idle(3);
    chk("activity masked", 32'h104, {23'h0, p_out.locked, p_out.loss, p_out.bw_sel});
    apb(1'b1, DPL_LOSS_EN_OFS, 32'hf);
    p_run <= 1'b1;
    p_lim <= 1'b1;
    idle(100);
    chk("freq limit loss", 32'h4, {28'h0, p_out.loss});
    p_lim <= 1'b0;
    idle(4);
    complete_run();
  end
endmodule

bind dpl_loop_ctrl dpl_loop_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .primary_out(primary_out), .secondary_out(secondary_out));
